// ===== design/dhrs_pkg.sv
// Constants, types and helpers for the display hardware-reset sequencer
package dhrs_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int NS_PER_US = 1000;

    // Reset pin pulse qualification
    localparam int T_REJECT_NS = 5000;
    localparam int T_ACCEPT_NS = 9000;
    localparam int SYNC_STAGES = 2;
    localparam int REJECT_CYC =
        (T_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCEPT_CYC = T_ACCEPT_NS / CLK_PERIOD_NS;
    localparam int FILT_W = 8;
    localparam logic [FILT_W-1:0] QUAL_LAST = FILT_W'(REJECT_CYC - 1);
    localparam logic [FILT_W-1:0] FILT_ZERO = 8'h00;
    localparam logic [FILT_W-1:0] FILT_ONE = 8'h01;
    // Cycles from a pin edge to the qualified edge
    localparam int FILT_LAG_CYC = REJECT_CYC + SYNC_STAGES + 1;

    // Reset-cancel and blanking times
    localparam int T_CANCEL_SLEEP_US = 5000;
    localparam int T_CANCEL_AWAKE_US = 120000;
    localparam int T_BLANK_US = 120000;
    localparam int CMD_WAIT_CYC =
        T_CANCEL_SLEEP_US * NS_PER_US / CLK_PERIOD_NS - FILT_LAG_CYC;
    localparam int WAKE_WAIT_CYC =
        T_CANCEL_AWAKE_US * NS_PER_US / CLK_PERIOD_NS - FILT_LAG_CYC;
    localparam int BLANK_CYC = T_BLANK_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int TMR_W = 22;
    localparam logic [TMR_W-1:0] TMR_ZERO = 22'h000000;
    localparam logic [TMR_W-1:0] TMR_ONE = 22'h000001;
    localparam logic [TMR_W-1:0] TMR_MAX = 22'h3FFFFF;

    // Nonvolatile settings image
    localparam int NVM_DW = 8;
    localparam int NVM_AW = 3;
    localparam int ID_WORDS = 3;
    localparam int SET_WORDS = 4;
    localparam int NVM_WORDS = 8;
    localparam int ID_BASE = 0;
    localparam int CV_IDX = 3;
    localparam int SET_BASE = 4;
    localparam logic [NVM_AW-1:0] NVM_LAST = 3'h7;
    localparam logic [NVM_AW-1:0] NVM_FIRST = 3'h0;
    localparam logic [NVM_AW-1:0] NVM_STEP = 3'h1;
    localparam logic [NVM_DW-1:0] ID_DEFAULT = 8'h00;
    localparam logic [NVM_DW-1:0] CV_DEFAULT = 8'h20;
    localparam logic [NVM_DW-1:0] SET_DEFAULT = 8'h00;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HOLD,
        ST_LOAD,
        ST_SETTLE
    } dhrs_state_e;

    // Saturating timer step, shared by all long timers
    function automatic logic [TMR_W-1:0] tmr_step(input logic [TMR_W-1:0] v);
        tmr_step = (v == TMR_MAX) ? v : v + TMR_ONE;
    endfunction : tmr_step

    function automatic logic [NVM_DW-1:0] word_default(input int idx);
        if (idx == CV_IDX) begin
            word_default = CV_DEFAULT;
        end else if (idx < ID_WORDS) begin
            word_default = ID_DEFAULT;
        end else begin
            word_default = SET_DEFAULT;
        end
    endfunction : word_default

endpackage : dhrs_pkg

// ===== design/dhrs_filt_if.sv
// Qualified reset events from the pin filter to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface dhrs_filt_if;
    logic rst_level;
    logic start_pulse;
    logic release_pulse;
    modport src (output rst_level, output start_pulse, output release_pulse);
    modport snk (input rst_level, input start_pulse, input release_pulse);
endinterface : dhrs_filt_if
`default_nettype wire

// ===== design/dhrs_pulse_filter.sv
// Synchroniser and pulse-width filter for the hardware reset pin
`timescale 1ns/1ps
`default_nettype none
module dhrs_pulse_filter
    import dhrs_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Pin
    input wire logic hw_reset_n_in,
    // Qualified events
    dhrs_filt_if.src filt
);

    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic start_q;
    logic release_q;
    logic [FILT_W-1:0] cnt_q;
    logic differ;

    // Sync stages rest high: no reset requested
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= hw_reset_n_in;
            sync2_q <= sync1_q;
        end
    end

    // Pin disagrees with the accepted level
    assign differ = (~sync2_q) != level_q;

    // Same width test both ways, so spikes during reset are rejected too
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= FILT_ZERO;
            level_q <= 1'b0;
            start_q <= 1'b0;
            release_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            release_q <= 1'b0;
            if (!differ) begin
                cnt_q <= FILT_ZERO;
            end else if (cnt_q == QUAL_LAST) begin
                cnt_q <= FILT_ZERO;
                level_q <= ~level_q;
                start_q <= ~level_q;
                release_q <= level_q;
            end else begin
                cnt_q <= cnt_q + FILT_ONE;
            end
        end
    end

    assign filt.rst_level = level_q;
    assign filt.start_pulse = start_q;
    assign filt.release_pulse = release_q;

endmodule : dhrs_pulse_filter
`default_nettype wire

// ===== design/dhrs_top.sv
// Hardware-reset sequencer: pin qualification, blanking, settings reload
`timescale 1ns/1ps
`default_nettype none
module dhrs_top
    import dhrs_pkg::*;
#(
    parameter int CMD_WAIT = CMD_WAIT_CYC,
    parameter int WAKE_WAIT = WAKE_WAIT_CYC,
    parameter int BLANK_TIME = BLANK_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Host reset pin and power state
    input wire logic hw_reset_n_in,
    input wire logic sleep_out_in,
    // Nonvolatile memory read port
    output logic nvm_rd_out,
    output logic [NVM_AW-1:0] nvm_addr_out,
    input wire logic [NVM_DW-1:0] nvm_data_in,
    input wire logic nvm_ack_in,
    // Status towards the rest of the controller
    output logic display_blank_out,
    output logic resetting_out,
    output logic defaults_out,
    output logic load_fail_out,
    output logic cmd_ready_out,
    output logic wake_ready_out,
    // Reloaded settings
    output logic [ID_WORDS*NVM_DW-1:0] id_bytes_out,
    output logic [NVM_DW-1:0] common_voltage_setting_out,
    output logic [SET_WORDS*NVM_DW-1:0] settings_out
);

    localparam logic [TMR_W-1:0] CMD_LIM = TMR_W'(CMD_WAIT);
    localparam logic [TMR_W-1:0] WAKE_LIM = TMR_W'(WAKE_WAIT);
    localparam logic [TMR_W-1:0] BLANK_LIM = TMR_W'(BLANK_TIME);

    dhrs_filt_if filt ();

    dhrs_pulse_filter u_filter (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .hw_reset_n_in(hw_reset_n_in),
        .filt(filt.src)
    );

    dhrs_state_e state_q;
    logic awake_q;
    logic blank_q;
    logic [TMR_W-1:0] blank_tmr_q;
    logic [TMR_W-1:0] rel_tmr_q;
    logic [NVM_AW-1:0] idx_q;
    logic pend_q;
    logic rd_q;
    logic loaded_q;
    logic fail_q;
    logic defaults_q;
    logic cmd_ready_q;
    logic wake_ready_q;
    logic resetting_q;
    logic [NVM_DW-1:0] image_q [NVM_WORDS];
    logic blank_done;
    logic load_over;
    logic in_load;

    // Asleep at reset start means the panel is already blank
    assign blank_done = !awake_q || (blank_tmr_q >= BLANK_LIM);
    assign load_over = loaded_q || fail_q;
    assign in_load = state_q == ST_LOAD;

    // Sequence state
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_LOAD;
            resetting_q <= 1'b1;
        end else if (filt.start_pulse) begin
            state_q <= ST_HOLD;
            resetting_q <= 1'b1;
        end else begin
            case (state_q)
                ST_HOLD: begin
                    if (filt.release_pulse) begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (load_over) begin
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (blank_done) begin
                        state_q <= ST_RUN;
                        resetting_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                    resetting_q <= 1'b0;
                end
            endcase
        end
    end

    // Blanking sequence, timed from the accepted reset start
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            awake_q <= 1'b0;
            blank_q <= 1'b1;
            blank_tmr_q <= TMR_ZERO;
        end else if (filt.start_pulse) begin
            awake_q <= sleep_out_in;
            blank_q <= 1'b1;
            blank_tmr_q <= TMR_ZERO;
        end else begin
            if (awake_q) begin
                blank_tmr_q <= tmr_step(blank_tmr_q);
            end
            if (state_q == ST_SETTLE && blank_done) begin
                blank_q <= 1'b0;
            end
        end
    end

    // Time since the qualified release, shared by both host waits
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rel_tmr_q <= TMR_ZERO;
        end else if (filt.start_pulse || filt.release_pulse) begin
            rel_tmr_q <= TMR_ZERO;
        end else if (!filt.rst_level) begin
            rel_tmr_q <= tmr_step(rel_tmr_q);
        end
    end

    // Readiness hints; the offsets absorb the filter's release lag
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_ready_q <= 1'b0;
            wake_ready_q <= 1'b0;
        end else begin
            cmd_ready_q <= (state_q == ST_RUN) && !filt.start_pulse
                && (rel_tmr_q >= CMD_LIM);
            wake_ready_q <= (state_q == ST_RUN) && !filt.start_pulse
                && (rel_tmr_q >= WAKE_LIM);
        end
    end

    // NVM fetch: one outstanding read at a time
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            idx_q <= NVM_FIRST;
            pend_q <= 1'b0;
            rd_q <= 1'b0;
            loaded_q <= 1'b0;
            fail_q <= 1'b0;
        end else if (filt.start_pulse || !in_load) begin
            rd_q <= 1'b0;
            pend_q <= 1'b0;
            idx_q <= NVM_FIRST;
            if (filt.start_pulse || filt.release_pulse) begin
                loaded_q <= 1'b0;
                fail_q <= 1'b0;
            end
        end else if (!load_over) begin
            rd_q <= 1'b0;
            if (rel_tmr_q >= CMD_LIM) begin
                fail_q <= 1'b1;
                pend_q <= 1'b0;
            end else if (!pend_q) begin
                rd_q <= 1'b1;
                pend_q <= 1'b1;
            end else if (nvm_ack_in && !rd_q) begin
                pend_q <= 1'b0;
                if (idx_q == NVM_LAST) begin
                    loaded_q <= 1'b1;
                end else begin
                    idx_q <= idx_q + NVM_STEP;
                end
            end
        end
    end

    // Settings image: defaults on reset start, then the NVM words
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NVM_WORDS; i++) begin
                image_q[i] <= word_default(i);
            end
        end else if (filt.start_pulse) begin
            for (int i = 0; i < NVM_WORDS; i++) begin
                image_q[i] <= word_default(i);
            end
        end else if (in_load && pend_q && !rd_q && nvm_ack_in
                && !load_over) begin
            image_q[idx_q] <= nvm_data_in;
        end
    end

    // One-cycle notice that the default condition has been entered
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            defaults_q <= 1'b0;
        end else begin
            defaults_q <= (state_q == ST_SETTLE) && blank_done
                && !filt.start_pulse;
        end
    end

    assign nvm_rd_out = rd_q;
    assign nvm_addr_out = idx_q;
    assign display_blank_out = blank_q;
    assign resetting_out = resetting_q;
    assign defaults_out = defaults_q;
    assign load_fail_out = fail_q;
    assign cmd_ready_out = cmd_ready_q;
    assign wake_ready_out = wake_ready_q;

    always_comb begin
        for (int i = 0; i < ID_WORDS; i++) begin
            id_bytes_out[i*NVM_DW +: NVM_DW] = image_q[ID_BASE + i];
        end
        for (int i = 0; i < SET_WORDS; i++) begin
            settings_out[i*NVM_DW +: NVM_DW] = image_q[SET_BASE + i];
        end
    end

    assign common_voltage_setting_out = image_q[CV_IDX];

endmodule : dhrs_top
`default_nettype wire

// ===== tb/dhrs_top_monitor.sv
// Port checker for the hardware-reset sequencer
`timescale 1ns/1ps
`default_nettype none
module dhrs_top_monitor
    import dhrs_pkg::*;
#(
    parameter int WAKE_WAIT = WAKE_WAIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Watched ports
    input wire logic hw_reset_n_in,
    input wire logic nvm_rd_out,
    input wire logic display_blank_out,
    input wire logic resetting_out,
    input wire logic defaults_out,
    input wire logic cmd_ready_out,
    input wire logic wake_ready_out
);
    logic pin_q;
    logic [7:0] run_q;
    logic [21:0] rel_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Length of the latest low run, held after the pin rises
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_q <= 1'b1;
            run_q <= 8'h00;
        end else begin
            pin_q <= hw_reset_n_in;
            if (!hw_reset_n_in) begin
                run_q <= pin_q ? 8'h01 : run_q + {7'h00, run_q != 8'hFF};
            end
        end
    end
    // Cycles spent resetting with the pin already high
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rel_q <= 22'h000000;
        end else begin
            rel_q <= (resetting_out && hw_reset_n_in) ? rel_q + 22'h000001
                                                       : 22'h000000;
        end
    end
    property p_accept;
        !hw_reset_n_in && run_q == 8'h8C |-> resetting_out;
    endproperty
    a_accept: assert property (p_accept) else $error("long low ignored");
    property p_reject;
        $rose(resetting_out) |-> run_q >= 8'h7D;
    endproperty
    a_reject: assert property (p_reject) else $error("short low taken");
    property p_blank;
        resetting_out |-> display_blank_out;
    endproperty
    a_blank: assert property (p_blank) else $error("not blanked");
    property p_dflt;
        $fell(resetting_out) |-> defaults_out && !display_blank_out;
    endproperty
    a_dflt: assert property (p_dflt) else $error("no default entry");
    property p_rd;
        nvm_rd_out |=> !nvm_rd_out;
    endproperty
    a_rd: assert property (p_rd) else $error("read not a pulse");
    property p_rdres;
        nvm_rd_out |-> resetting_out;
    endproperty
    a_rdres: assert property (p_rdres) else $error("read outside reset");
    property p_cmd;
        resetting_out [*2] |-> !cmd_ready_out;
    endproperty
    a_cmd: assert property (p_cmd) else $error("ready in reset");
    property p_wake;
        wake_ready_out |-> cmd_ready_out;
    endproperty
    a_wake: assert property (p_wake) else $error("wake before cmd");
    property p_cancel;
        int'(rel_q) <= WAKE_WAIT + FILT_LAG_CYC;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel too long");
endmodule : dhrs_top_monitor
bind dhrs_top dhrs_top_monitor #(.WAKE_WAIT(WAKE_WAIT)) u_mon (
    .clk_in(clk_in), .nrst_in(nrst_in), .hw_reset_n_in(hw_reset_n_in),
    .nvm_rd_out(nvm_rd_out), .display_blank_out(display_blank_out),
    .resetting_out(resetting_out), .defaults_out(defaults_out),
    .cmd_ready_out(cmd_ready_out), .wake_ready_out(wake_ready_out));
`default_nettype wire

// ===== tb/dhrs_nvm_model.sv
// Behavioural nonvolatile memory answering the reload reads
`timescale 1ns/1ps
`default_nettype none
module dhrs_nvm_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Read port
    input wire logic rd_in,
    input wire logic [2:0] addr_in,
    output logic [7:0] data_out,
    output logic ack_out,
    // Test controls
    input wire logic slow_in,
    input wire logic mute_in,
    input wire logic [7:0] key_in
);
    logic busy_q;
    logic [2:0] cnt_q;
    logic [2:0] addr_q;
    logic [7:0] word;
    assign word = key_in + {5'h00, addr_q};
    // Off-ack data inverted so a stale word never matches
    assign data_out = ack_out ? word : ~word;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_q <= 1'b0;
            cnt_q <= 3'h0;
            addr_q <= 3'h0;
            ack_out <= 1'b0;
        end else begin
            ack_out <= 1'b0;
            if (rd_in) begin
                busy_q <= 1'b1;
                cnt_q <= slow_in ? 3'h5 : 3'h1;
                addr_q <= addr_in;
            end else if (busy_q && cnt_q == 3'h0) begin
                busy_q <= 1'b0;
                ack_out <= !mute_in;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
endmodule : dhrs_nvm_model
`default_nettype wire

// ===== tb/dhrs_top_test.sv
// Self-checking bench for the hardware-reset sequencer
`timescale 1ns/1ps
`default_nettype none
module dhrs_top_test;
    import dhrs_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic pin = 1'b1;
    logic sleep = 1'b1;
    logic slow = 1'b0;
    logic mute = 1'b0;
    logic [7:0] key = 8'hA0;
    logic rd, ack, blank, res, dflt, fail, cmd, wake;
    logic [2:0] addr;
    logic [7:0] data, cv;
    logic [23:0] ids;
    logic [31:0] sets;
    int bad_count = 0;
    int num_checks = 0;
    always #20 clk_in = ~clk_in;
    dhrs_top #(.CMD_WAIT(200), .WAKE_WAIT(400), .BLANK_TIME(300)) u_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .hw_reset_n_in(pin),
        .sleep_out_in(sleep), .nvm_rd_out(rd), .nvm_addr_out(addr),
        .nvm_data_in(data), .nvm_ack_in(ack), .display_blank_out(blank),
        .resetting_out(res), .defaults_out(dflt), .load_fail_out(fail),
        .cmd_ready_out(cmd), .wake_ready_out(wake), .id_bytes_out(ids),
        .common_voltage_setting_out(cv), .settings_out(sets));
    dhrs_nvm_model u_nvm (
        .clk_in(clk_in), .nrst_in(nrst_in), .rd_in(rd), .addr_in(addr),
        .data_out(data), .ack_out(ack), .slow_in(slow), .mute_in(mute),
        .key_in(key));
    task automatic results();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: %s got %0h", $time, m, got);
        end
    endtask : chk
    function automatic logic sel(input int w);
        case (w)
            0: sel = res;
            1: sel = cmd;
            2: sel = wake;
            default: sel = fail;
        endcase
    endfunction : sel
    // Bounded wait, n counts the falling edges passed
    task automatic wait_for(input int w, input logic v, output int n);
        n = 0;
        while (sel(w) !== v) begin
            @(negedge clk_in);
            n++;
            if (n > 3000) begin
                chk(32'h0, 32'h1, "timeout");
                results();
            end
        end
    endtask : wait_for
    task automatic low(input int c);
        pin = 1'b0;
        repeat (c) @(negedge clk_in);
        pin = 1'b1;
    endtask : low
    task automatic chk_img();
        for (int i = 0; i < 3; i++) chk(ids[i*8+:8], key + i, "id");
        chk(cv, key + 8'h03, "cv");
        for (int i = 0; i < 4; i++) begin
            chk(sets[i*8+:8], key + 4 + i, "set");
        end
    endtask : chk_img
    task automatic t_boot();
        int n, m;
        wait_for(1, 1'b1, n);
        chk(n >= 195 && n <= 206, 32'h1, "cmd wait");
        wait_for(2, 1'b1, m);
        chk(n + m >= 395 && n + m <= 406, 32'h1, "wake wait");
        chk_img();
    endtask : t_boot
    task automatic t_short();
        // Just under the acceptance threshold
        low(124);
        repeat (200) @(negedge clk_in);
        chk(res, 1'b0, "spike taken");
        chk(cmd, 1'b1, "ready lost");
    endtask : t_short
    task automatic t_awake();
        int n;
        slow = 1'b1;
        key = 8'h50;
        low(150);
        chk(res, 1'b1, "reset missed");
        chk(cv, CV_DEFAULT, "cv default");
        // High glitch of 40 cycles inside the accepted reset
        repeat (40) @(negedge clk_in);
        low(150);
        chk(res, 1'b1, "glitch taken");
        chk(cmd, 1'b0, "ready in reset");
        wait_for(0, 1'b0, n);
        chk(n >= 198 && n <= 206, 32'h1, "cancel time");
        chk(n <= 528, 32'h1, "cancel long");
        chk({dflt, blank}, 2'b10, "defaults");
        chk_img();
        slow = 1'b0;
    endtask : t_awake
    // Shortest accepted low; blanking outlasts the reload here
    task automatic t_blank();
        int n, m;
        key = 8'h60;
        low(125);
        wait_for(0, 1'b1, n);
        chk(n, 32'h3, "edge lag");
        chk(blank, 1'b1, "not blanked");
        chk(cmd, 1'b0, "ready kept");
        wait_for(0, 1'b0, m);
        chk(m, 32'h12D, "blank time");
        chk({dflt, blank}, 2'b10, "defaults");
        chk_img();
    endtask : t_blank
    task automatic t_asleep();
        int n;
        sleep = 1'b0;
        key = 8'h30;
        low(200);
        wait_for(0, 1'b0, n);
        chk(n + 72 < 300, 32'h1, "blank seq asleep");
        chk(n <= 328, 32'h1, "cancel long");
        chk_img();
    endtask : t_asleep
    task automatic t_fail();
        int n;
        mute = 1'b1;
        low(200);
        wait_for(3, 1'b1, n);
        chk(res, 1'b1, "fail outside reset");
        mute = 1'b0;
        wait_for(0, 1'b0, n);
        wait_for(1, 1'b1, n);
    endtask : t_fail
    initial begin
        repeat (4) @(negedge clk_in);
        nrst_in = 1'b1;
        t_boot();
        t_short();
        t_awake();
        t_blank();
        t_asleep();
        t_fail();
        results();
    end
endmodule : dhrs_top_test
`default_nettype wire
